// ### rtl/aal1_ces_perf_alarm.sv
/*
  AAL1 unstructured circuit emulation: sending-side assembly with signal
  loss substitution and congestion discard count, receiving-side playout
  with cell loss estimate, starvation fill and interval statistics.
  Assumes the ATM side and the playout bit tick run on ref_clk; the DSn
  line pins are asynchronous.
*/
// Function
// R1: Count sent PDUs discarded on congestion
// R2: Count received PDUs dropped, buffer full
// R3: Estimate lost payloads from sequence gaps, unstarved
// R4: Starved when receive buffer is empty and no block plays or waits
// R5: Pulse at start and end of starvation
// R6: Per interval count starvation episodes and time
// R7: Interval fifteen minutes, eight hours history
// R8: Declare signal loss on zero run or silence
// R9: Framing loss reported as signal loss
// R10: Substitute fill pattern into outgoing payloads
// R11: Upstream fill passes unchanged as data
// R12: Output fill pattern while starved
// R13: Sequence count modulo eight per payload
// R14: One fill block per lost payload
// R15: Starvation ends when payloads arrive again
// R16: Boundary copies counters to history, clears them
`timescale 1ns/1ps
`default_nettype none

module aal1_ces_perf_alarm
  import ces_pkg::*;
#(
  parameter int ZERO_RUN_LIMIT = ZERO_RUN_NOM,
  parameter int NO_PULSE_LIMIT = NO_PULSE_CYCLES,
  parameter logic [TIME_W-1:0] INTERVAL_LEN = INTERVAL_CYCLES,
  parameter int HIST_SLOTS = HIST_DEPTH,
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tx_line_clk,
  input wire logic tx_line_data,
  input wire logic framing_lost,
  output logic signal_absent,
  output logic tx_cell_valid,
  input wire logic tx_cell_ready,
  output logic [PDU_BITS-1:0] tx_cell_data,
  input wire logic rx_cell_valid,
  input wire logic [PDU_BITS-1:0] rx_cell_data,
  input wire logic rx_bit_tick,
  output logic rx_line_data,
  output logic rx_line_strobe,
  output logic alarm_fill_active,
  output logic fill_start,
  output logic fill_stop,
  output logic interval_done,
  input wire logic [$clog2(HIST_SLOTS)-1:0] hist_index,
  output logic [CNT_W-1:0] hist_discard,
  output logic [CNT_W-1:0] hist_overflow,
  output logic [CNT_W-1:0] hist_lost,
  output logic [CNT_W-1:0] hist_starve_events,
  output logic [TIME_W-1:0] hist_starve_time
);

  localparam int HPTR_W = $clog2(HIST_SLOTS);
  localparam logic [HPTR_W-1:0] HPTR_LAST = HPTR_W'(HIST_SLOTS - 1);
  localparam logic [TIME_W-1:0] IVL_LAST = INTERVAL_LEN - 1'b1;

  // Counter step: a boundary restarts at this cycle's increment
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] cnt,
                                            input logic [CNT_W-1:0] inc,
                                            input logic restart);
    return restart ? inc : cnt + inc;
  endfunction

  stream_if #(.W(PDU_BITS)) tx_in ();
  stream_if #(.W(PDU_BITS)) tx_out ();
  stream_if #(.W(PDU_BITS)) rx_in ();
  stream_if #(.W(PDU_BITS)) rx_out ();

  logic line_tick;
  logic line_bit;
  logic absent;

  // Line sampling and signal loss detection
  line_loss_detect #(
    .ZERO_RUN_LIMIT(ZERO_RUN_LIMIT),
    .NO_PULSE_LIMIT(NO_PULSE_LIMIT)
  ) u_loss (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .line_clk(tx_line_clk),
    .line_data(tx_line_data),
    .framing_lost(framing_lost),
    .bit_tick(line_tick),
    .bit_value(line_bit),
    .signal_absent(absent)
  );

  // Sending buffer toward the ATM layer
  stream_fifo #(
    .W(PDU_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_tx_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_s(tx_in),
    .out_s(tx_out)
  );

  // Receiving cell buffer
  stream_fifo #(
    .W(PDU_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_rx_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_s(rx_in),
    .out_s(rx_out)
  );

  // Sending side state
  logic [PAYLOAD_BITS-1:0] tx_payload;
  logic [BIT_CNT_W-1:0] tx_bit_cnt;
  logic [SEQ_W-1:0] tx_seq;
  logic [PDU_BITS-1:0] tx_pdu;
  logic tx_push;

  // Sending side decode; only a locally detected loss is substituted
  wire tx_bit = absent ? ALARM_FILL_BIT : line_bit; // R10 R11
  wire tx_last = tx_bit_cnt == BLOCK_LAST;
  wire [PAYLOAD_BITS-1:0] next_tx_payload = {tx_payload[PAYLOAD_BITS-2:0], tx_bit};
  wire tx_drop = tx_push && !tx_in.ready; // R1

  assign tx_in.valid = tx_push;
  assign tx_in.data = tx_pdu;
  assign tx_out.ready = tx_cell_ready;
  assign tx_cell_valid = tx_out.valid;
  assign tx_cell_data = tx_out.data;

  // Payload blocking and PDU assembly
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_payload <= '0;
      tx_bit_cnt <= '0;
      tx_seq <= '0;
      tx_pdu <= '0;
      tx_push <= 1'b0;
    end
    else
    begin
      tx_push <= line_tick && tx_last;
      if (line_tick)
      begin
        tx_payload <= next_tx_payload;
        tx_bit_cnt <= tx_last ? '0 : tx_bit_cnt + 1'b1;
      end
      if (line_tick && tx_last)
      begin
        tx_pdu <= {sar_header(tx_seq), next_tx_payload};
        tx_seq <= tx_seq + 1'b1; // R13
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      signal_absent <= 1'b0;
    else
      signal_absent <= absent;
  end

  // Receiving side state
  play_t play_state;
  logic [BIT_CNT_W-1:0] play_left;
  logic [PAYLOAD_BITS-1:0] play_shift;
  logic [SEQ_W-1:0] fill_pending;
  logic [SEQ_W-1:0] rx_expect;
  logic seq_known;
  logic starved;

  // Receive decode
  wire rx_drop = rx_cell_valid && !rx_in.ready; // R2
  wire [SEQ_W-1:0] rx_seq = rx_out.data[SEQ_MSB -: SEQ_W];
  wire [SEQ_W-1:0] rx_gap = rx_seq - rx_expect;
  wire play_idle = play_left == '0;
  wire play_free = play_idle && (fill_pending == '0);
  wire gap_hit = play_free && rx_out.valid && seq_known && !starved
                 && (rx_gap != '0); // R3
  wire pop = play_free && rx_out.valid && !gap_hit; // R15
  wire fill_go = play_idle && (fill_pending != '0); // R14
  wire next_starved = play_free && !rx_out.valid; // R4
  wire play_end = rx_bit_tick && (play_left == 1);
  wire start_w = next_starved && !starved;
  wire stop_w = !next_starved && starved;

  assign rx_in.valid = rx_cell_valid;
  assign rx_in.data = rx_cell_data;
  assign rx_out.ready = pop;

  // Next playout state; a gap opens its first fill block at once, so no idle bit slips in
  wire play_t next_play_state = (fill_go || gap_hit) ? PLAY_FILL : pop ? PLAY_DATA :
                                play_end ? PLAY_IDLE : play_state; // R14
  wire [BIT_CNT_W-1:0] next_play_left = (fill_go || gap_hit || pop) ? BLOCK_BITS :
                                        (rx_bit_tick && !play_idle) ? play_left - 1'b1 :
                                        play_left;

  // Bit selected for the line: data only from a held payload
  logic play_bit;
  always_comb
  begin
    unique case (play_state)
      PLAY_IDLE: play_bit = ALARM_FILL_BIT; // R12
      PLAY_FILL: play_bit = ALARM_FILL_BIT; // R14
      PLAY_DATA: play_bit = play_shift[PAYLOAD_BITS-1];
      default: play_bit = ALARM_FILL_BIT;
    endcase
  end

  // Playout sequencing and sequence tracking
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      play_state <= PLAY_IDLE;
      play_left <= '0;
      play_shift <= '0;
      fill_pending <= '0;
      rx_expect <= '0;
      seq_known <= 1'b0;
      starved <= 1'b0;
    end
    else
    begin
      play_state <= next_play_state;
      play_left <= next_play_left;
      starved <= next_starved; // R4
      if (pop)
        play_shift <= rx_out.data[PAYLOAD_BITS-1:0];
      else if (rx_bit_tick && (play_state == PLAY_DATA))
        play_shift <= {play_shift[PAYLOAD_BITS-2:0], 1'b0};
      if (gap_hit)
        fill_pending <= rx_gap - 1'b1; // R14
      else if (fill_go)
        fill_pending <= fill_pending - 1'b1;
      if (gap_hit)
        rx_expect <= rx_seq; // R3
      else if (pop)
      begin
        rx_expect <= rx_seq + 1'b1; // R13 R15
        seq_known <= 1'b1;
      end
    end
  end

  // Line and alarm outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_line_data <= ALARM_FILL_BIT;
      rx_line_strobe <= 1'b0;
      alarm_fill_active <= 1'b0;
      fill_start <= 1'b0;
      fill_stop <= 1'b0;
    end
    else
    begin
      if (rx_bit_tick)
        rx_line_data <= play_bit; // R12
      rx_line_strobe <= rx_bit_tick;
      alarm_fill_active <= next_starved || (next_play_state == PLAY_FILL);
      fill_start <= start_w; // R5
      fill_stop <= stop_w; // R5
    end
  end

  // Interval statistics
  logic [TIME_W-1:0] ivl_cnt;
  hist_rec_t cur;
  hist_rec_t hist_mem [HIST_SLOTS];
  logic [HPTR_W-1:0] hist_wr;
  hist_rec_t hist_q;

  wire boundary = ivl_cnt == IVL_LAST; // R7

  // Interval timer and current counters
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ivl_cnt <= '0;
      cur <= '0;
      interval_done <= 1'b0;
    end
    else
    begin
      ivl_cnt <= boundary ? '0 : ivl_cnt + 1'b1; // R7
      interval_done <= boundary;
      cur.discard <= bump(cur.discard, CNT_W'(tx_drop), boundary); // R1 R16
      cur.overflow <= bump(cur.overflow, CNT_W'(rx_drop), boundary); // R2 R16
      cur.lost <= bump(cur.lost, gap_hit ? CNT_W'(rx_gap) : '0, boundary); // R3 R16
      cur.starve_events <= bump(cur.starve_events, CNT_W'(start_w), boundary); // R6
      cur.starve_time <= boundary ? TIME_W'(starved) :
                         cur.starve_time + TIME_W'(starved); // R6
    end
  end

  // History ring: newest slot overwrites the oldest
  always_ff @(posedge ref_clk)
  begin
    if (boundary)
      hist_mem[hist_wr] <= cur; // R16
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_wr <= '0;
      hist_q <= '0;
    end
    else
    begin
      if (boundary)
        hist_wr <= (hist_wr == HPTR_LAST) ? '0 : hist_wr + 1'b1; // R16
      hist_q <= hist_mem[hist_index];
    end
  end

  assign hist_discard = hist_q.discard;
  assign hist_overflow = hist_q.overflow;
  assign hist_lost = hist_q.lost;
  assign hist_starve_events = hist_q.starve_events;
  assign hist_starve_time = hist_q.starve_time;

endmodule // aal1_ces_perf_alarm

`default_nettype wire

// ### rtl/ces_pkg.sv
/*
  Shared constants, types and helper functions for the AAL1 circuit
  emulation alarm and performance block.
  Assumes a single 40 MHz reference clock and 47-octet SAR payloads.
*/
`default_nettype none

package ces_pkg;

  // Reference clock
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;

  // SAR_PDU layout: 4-bit sequence field, 4-bit protection, 47 octets
  localparam int PAYLOAD_OCTETS = 47;
  localparam int PAYLOAD_BITS = PAYLOAD_OCTETS * 8;
  localparam int HDR_BITS = 8;
  localparam int PDU_BITS = PAYLOAD_BITS + HDR_BITS;
  localparam int BIT_CNT_W = $clog2(PAYLOAD_BITS + 1);
  localparam logic [BIT_CNT_W-1:0] BLOCK_BITS = BIT_CNT_W'(PAYLOAD_BITS);
  localparam logic [BIT_CNT_W-1:0] BLOCK_LAST = BIT_CNT_W'(PAYLOAD_BITS - 1);
  localparam int SEQ_W = 3;
  localparam int SEQ_MSB = PDU_BITS - 2;
  localparam logic CSI_BIT = 1'b0;

  // Signal loss: 175 +/- 75 zeros; the nominal figure is the default
  localparam int ZERO_RUN_NOM = 175;
  localparam int ZERO_RUN_TOL = 75;
  localparam int ZERO_RUN_W = 8;
  localparam int NO_PULSE_US = 10;
  localparam int NO_PULSE_CYCLES = NO_PULSE_US * (CLK_HZ / 1_000_000);

  // Fill pattern: unframed all-ones
  localparam logic ALARM_FILL_BIT = 1'b1;

  // Measurement intervals and history
  localparam int INTERVAL_MIN = 15;
  localparam int SEC_PER_MIN = 60;
  localparam int HIST_HOURS = 8;
  localparam int HIST_DEPTH = HIST_HOURS * SEC_PER_MIN / INTERVAL_MIN;
  localparam int CNT_W = 32;
  localparam int TIME_W = 36;
  localparam logic [TIME_W-1:0] INTERVAL_CYCLES =
    TIME_W'(64'(INTERVAL_MIN) * 64'(SEC_PER_MIN) * 64'(CLK_HZ));

  // Cell buffers
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    PLAY_IDLE = 2'b00,
    PLAY_FILL = 2'b01,
    PLAY_DATA = 2'b10
  } play_t;

  typedef struct packed {
    logic [CNT_W-1:0] discard;
    logic [CNT_W-1:0] overflow;
    logic [CNT_W-1:0] lost;
    logic [CNT_W-1:0] starve_events;
    logic [TIME_W-1:0] starve_time;
  } hist_rec_t;

  // Header: CSI, sequence count, CRC-3 (x^3+x+1) and even parity
  function automatic logic [HDR_BITS-1:0] sar_header(input logic [SEQ_W-1:0] seq);
    logic [3:0] sn;
    logic [2:0] r;
    logic fb;
    sn = {CSI_BIT, seq};
    r = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      fb = sn[i] ^ r[2];
      r = {r[1], r[0] ^ fb, fb};
    end
    return {sn, r, ^{sn, r}};
  endfunction

endpackage

`default_nettype wire

// ### rtl/line_loss_detect.sv
/*
  Samples the DSn line pins and declares signal absence.
  Assumes line clock and data are asynchronous pins, data valid at the
  rising edge of the line clock.
*/
`timescale 1ns/1ps
`default_nettype none

module line_loss_detect
  import ces_pkg::*;
#(
  parameter int ZERO_RUN_LIMIT = ZERO_RUN_NOM,
  parameter int NO_PULSE_LIMIT = NO_PULSE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic line_clk,
  input wire logic line_data,
  input wire logic framing_lost,
  output logic bit_tick,
  output logic bit_value,
  output logic signal_absent
);

  localparam int IDLE_W = $clog2(NO_PULSE_LIMIT + 1);
  localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(NO_PULSE_LIMIT);
  localparam logic [ZERO_RUN_W-1:0] RUN_MAX = ZERO_RUN_W'(ZERO_RUN_LIMIT);

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic clk_prev;
  logic [ZERO_RUN_W-1:0] zero_run;
  logic [IDLE_W-1:0] idle_cnt;

  // Synchronised pins: 0 clock, 1 data, 2 framing loss
  wire tick = sync2[0] && !clk_prev;
  wire [ZERO_RUN_W-1:0] next_zero_run =
    !tick ? zero_run : sync2[1] ? '0 : (zero_run == RUN_MAX) ? zero_run : zero_run + 1'b1;
  wire [IDLE_W-1:0] next_idle_cnt =
    tick ? '0 : (idle_cnt == IDLE_MAX) ? idle_cnt : idle_cnt + 1'b1;
  wire next_absent = (next_zero_run == RUN_MAX) || (next_idle_cnt == IDLE_MAX) // R8
                     || sync2[2]; // R9

  // Two-stage synchronisers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end
    else
    begin
      sync1 <= {framing_lost, line_data, line_clk};
      sync2 <= sync1;
    end
  end

  // Zero run, pulse watchdog and outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_prev <= 1'b0;
      zero_run <= '0;
      idle_cnt <= '0;
      bit_tick <= 1'b0;
      bit_value <= 1'b0;
      signal_absent <= 1'b0;
    end
    else
    begin
      clk_prev <= sync2[0];
      zero_run <= next_zero_run;
      idle_cnt <= next_idle_cnt;
      bit_tick <= tick;
      bit_value <= tick ? sync2[1] : bit_value;
      signal_absent <= next_absent; // R8
    end
  end

endmodule // line_loss_detect

`default_nettype wire

// ### rtl/stream_fifo.sv
/*
  Word FIFO with a registered output stage, valid and ready on both sides.
  Assumes the source offers a word only while it looks at ready.
*/
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  stream_if.snk in_s,
  stream_if.src out_s
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic out_valid;
  logic [W-1:0] out_data;

  // Handshake decode
  wire full = count == DEPTH_CNT;
  wire empty = count == '0;
  wire push = in_s.valid && !full;
  wire load = !empty && (!out_valid || out_s.ready);

  assign in_s.ready = !full;
  assign out_s.valid = out_valid;
  assign out_s.data = out_data;

  // Storage writes
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_s.data;
  end

  // Pointers, fill level and output stage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      if (load)
      begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end
      else if (out_s.ready)
        out_valid <= 1'b0;
      count <= count + (PTR_W + 1)'(push) - (PTR_W + 1)'(load);
    end
  end

endmodule // stream_fifo

`default_nettype wire

// ### rtl/stream_if.sv
/*
  Valid/ready word stream between the block's own modules.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface stream_if #(parameter int W = 8) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// ### verification/dsn_line_model.sv
/*
  Line source: drives the DSn line pins with a known pattern, zeros
  or silence. Assumes ref_clk is the bench clock, six cycles per bit.
*/
`timescale 1ns/1ps
`default_nettype none

module dsn_line_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  output logic tx_line_clk,
  output logic tx_line_data,
  output int bits_sent
);
  int ph;

  // Rise at phase 0, fall and new data at phase 3
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ph <= 0;
      tx_line_clk <= 1'b0;
      tx_line_data <= 1'b1;
      bits_sent <= 0;
    end
    else if (mode == 2'h2)
    begin
      tx_line_clk <= 1'b0;
      tx_line_data <= ~tx_line_data; // No stale level while silent
      ph <= 0;
    end
    else
    begin
      ph <= (ph == 5) ? 0 : ph + 1;
      if (ph == 0)
      begin
        tx_line_clk <= 1'b1;
        bits_sent <= bits_sent + 1;
      end
      if (ph == 3)
      begin
        tx_line_clk <= 1'b0;
        tx_line_data <= (mode == 2'h0) && (bits_sent % 3 == 0);
      end
    end
  end
endmodule // dsn_line_model

`default_nettype wire

// ### verification/perf_alarm_chk.sv
/*
  Port-level properties of the alarm and performance block.
  Assumes one clock domain; bound to the top module at the foot.
*/
`timescale 1ns/1ps
`default_nettype none

module perf_alarm_chk
  import ces_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic framing_lost,
  input wire logic signal_absent,
  input wire logic tx_cell_valid,
  input wire logic tx_cell_ready,
  input wire logic [PDU_BITS-1:0] tx_cell_data,
  input wire logic rx_bit_tick,
  input wire logic rx_line_data,
  input wire logic rx_line_strobe,
  input wire logic alarm_fill_active,
  input wire logic fill_start,
  input wire logic fill_stop,
  input wire logic interval_done
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Bit request answered by a strobe one cycle later
  sequence s_handover;
    rx_bit_tick ##1 rx_line_strobe;
  endsequence

  // Bit requested while fill plays, and fill still playing on the next cycle
  sequence s_fill_bit;
    (rx_bit_tick && alarm_fill_active) ##1 alarm_fill_active;
  endsequence

  a_strobe_after_tick: assert property (rx_bit_tick |-> s_handover)
    else $error("strobe missing after bit tick");
  a_strobe_has_cause: assert property (rx_line_strobe |-> $past(rx_bit_tick))
    else $error("strobe without bit tick");
  a_fill_emits_ones: assert property (s_fill_bit |-> rx_line_data)
    else $error("fill bit not one");
  a_start_in_fill: assert property (fill_start |-> alarm_fill_active)
    else $error("fill start without fill");
  a_start_is_pulse: assert property (fill_start |-> !fill_stop ##1 !fill_start)
    else $error("fill start not a lone pulse");
  a_stop_ends_starve: assert property (fill_stop |-> $past(alarm_fill_active))
    else $error("fill stop without prior fill");
  a_interval_spacing: assert property (interval_done |=> (!interval_done) [*8])
    else $error("interval boundaries too close");
  a_framing_to_absent: assert property (framing_lost [*4] |-> ##[0:3] signal_absent)
    else $error("framing loss not reported");
  a_tx_holds_cell: assert property (tx_cell_valid && !tx_cell_ready
    |=> tx_cell_valid && $stable(tx_cell_data))
    else $error("cell changed while stalled");
endmodule // perf_alarm_chk

bind aal1_ces_perf_alarm perf_alarm_chk u_chk (.ref_clk, .rst_n, .framing_lost,
  .signal_absent, .tx_cell_valid, .tx_cell_ready, .tx_cell_data, .rx_bit_tick,
  .rx_line_data, .rx_line_strobe, .alarm_fill_active, .fill_start, .fill_stop,
  .interval_done);

`default_nettype wire

// ### verification/test_aal1_ces_perf_alarm.sv
/*
  Bench: starvation, gap fill, overflow, history, signal loss and discard.
  Assumes the line model and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module test_aal1_ces_perf_alarm
  import ces_pkg::*;
;
  typedef struct packed {logic [2:0] seq; logic [7:0] fill_byte; logic [1:0] gap;} row_t;
  row_t rows [5] = '{'{3'h3, 8'hA5, 2'h0}, '{3'h4, 8'h3C, 2'h0},
    '{3'h6, 8'h0F, 2'h1}, '{3'h7, 8'hF0, 2'h0}, '{3'h2, 8'h96, 2'h2}};
  logic ref_clk = 1'b0, rst_n = 1'b0, framing_lost = 1'b0, tx_cell_ready = 1'b0;
  logic rx_cell_valid = 1'b0, rx_bit_tick = 1'b0;
  logic [PDU_BITS-1:0] rx_cell_data = '0;
  logic [4:0] hist_index = 5'h00;
  logic [1:0] mode = 2'h0;
  logic tx_line_clk, tx_line_data, signal_absent, tx_cell_valid, rx_line_data;
  logic rx_line_strobe, alarm_fill_active, fill_start, fill_stop, interval_done;
  logic [PDU_BITS-1:0] tx_cell_data;
  logic [CNT_W-1:0] hist_discard, hist_overflow, hist_lost, hist_starve_events;
  logic [TIME_W-1:0] hist_starve_time;
  int bits_sent, mismatches = 0, total_checks = 0, n_start = 0, n_stop = 0, n_starved = 0;
  logic in_ep = 1'b0, ivl_seen = 1'b0;

  always #12.5 ref_clk = ~ref_clk;

  dsn_line_model line (.ref_clk, .rst_n, .mode, .tx_line_clk, .tx_line_data, .bits_sent);

  aal1_ces_perf_alarm #(.NO_PULSE_LIMIT(60), .INTERVAL_LEN(36'hAFC8)) dut (.ref_clk,
    .rst_n, .tx_line_clk, .tx_line_data, .framing_lost, .signal_absent, .tx_cell_valid,
    .tx_cell_ready, .tx_cell_data, .rx_cell_valid, .rx_cell_data, .rx_bit_tick,
    .rx_line_data, .rx_line_strobe, .alarm_fill_active, .fill_start, .fill_stop,
    .interval_done, .hist_index, .hist_discard, .hist_overflow, .hist_lost,
    .hist_starve_events, .hist_starve_time);

  // Fill pulse tallies
  always @(posedge ref_clk)
  begin
    n_start <= n_start + int'(fill_start === 1'b1);
    n_stop <= n_stop + int'(fill_stop === 1'b1);
  end

  // Starved cycles framed by the fill pulses, up to the first boundary
  always @(posedge ref_clk)
  begin
    if (fill_start === 1'b1)
      in_ep <= 1'b1;
    else if (fill_stop === 1'b1)
      in_ep <= 1'b0;
    if (interval_done === 1'b1)
      ivl_seen <= 1'b1;
    else if (!ivl_seen)
      n_starved <= n_starved + int'(fill_start === 1'b1 || (in_ep && fill_stop !== 1'b1));
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [383:0] seen, input logic [383:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic send_cell(input logic [2:0] seq, input logic [7:0] b);
    rx_cell_data = {1'b0, seq, 4'h0, {47{b}}};
    rx_cell_valid = 1'b1;
    step(1);
    rx_cell_valid = 1'b0;
    step(1);
  endtask

  // Requests one block of output bits, first bit at the top
  task automatic play(output logic [375:0] got);
    for (int i = 375; i >= 0; i--)
    begin
      rx_bit_tick = 1'b1;
      step(1);
      rx_bit_tick = 1'b0;
      got[i] = rx_line_data;
      step(1);
    end
  endtask

  // Waits for an offered cell and takes it
  task automatic take(output logic [383:0] c);
    int k;
    k = 0;
    while (tx_cell_valid !== 1'b1 && k < 3000)
    begin
      step(1);
      k++;
    end
    c = tx_cell_data;
    step(1);
  endtask

  // Hang guard
  initial
  begin
    step(90000);
    mismatches++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    logic [375:0] got, first;
    logic [383:0] c;
    int mark;
    for (int n = 0; n < 376; n++)
      first[375 - n] = (n % 3 == 0);
    step(3);
    check(384'({rx_line_data, alarm_fill_active, signal_absent}), 384'(3'h4));
    rst_n = 1'b1;
    step(3);
    check(384'(alarm_fill_active), 384'(1'b1));
    play(got);
    check(384'(got), 384'({376{1'b1}}));
    foreach (rows[i])
      send_cell(rows[i].seq, rows[i].fill_byte);
    foreach (rows[i])
    begin
      repeat (rows[i].gap)
      begin
        play(got);
        check(384'(got), 384'({376{1'b1}}));
      end
      play(got);
      check(384'(got), 384'({47{rows[i].fill_byte}}));
    end
    for (int i = 0; i < 20; i++)
      send_cell(3'(i), 8'(i));
    for (int i = 0; i < 18; i++)
    begin
      play(got);
      check(384'(got), 384'({47{8'(i)}}));
    end
    play(got);
    check(384'(got), 384'({376{1'b1}}));
    check(384'(n_start), 384'(3));
    check(384'(n_stop), 384'(2));
    while (interval_done !== 1'b1)
      step(1);
    mark = bits_sent / 376;
    step(2);
    check(384'(hist_lost), 384'(3));
    check(384'(hist_overflow), 384'(2));
    check(384'(hist_starve_events), 384'(3));
    // Still starved at the boundary: that cycle counts in the new interval
    check(384'(hist_starve_time), 384'(n_starved - 1));
    check(384'(hist_discard), 384'(mark - 17));
    tx_cell_ready = 1'b1;
    for (int i = 0; i < 17; i++)
    begin
      take(c);
      check(384'(c[383:380]), 384'({1'b0, 3'(i)}));
      if (i == 0)
        check(384'(c[375:0]), 384'(first));
    end
    mode = 2'h1;
    mark = bits_sent;
    while (bits_sent < mark + 98)
      step(1);
    step(12);
    check(384'(signal_absent), 384'(1'b0));
    while (bits_sent < mark + 252)
      step(1);
    step(12);
    check(384'(signal_absent), 384'(1'b1));
    take(c);
    take(c);
    check(384'(c[375:0]), 384'({376{1'b1}}));
    mode = 2'h0;
    step(40);
    check(384'(signal_absent), 384'(1'b0));
    framing_lost = 1'b1;
    step(8);
    check(384'(signal_absent), 384'(1'b1));
    framing_lost = 1'b0;
    step(40);
    check(384'(signal_absent), 384'(1'b0));
    mode = 2'h2;
    step(50);
    check(384'(signal_absent), 384'(1'b0));
    step(20);
    check(384'(signal_absent), 384'(1'b1));
    mode = 2'h0;
    tally_and_finish();
  end
endmodule // test_aal1_ces_perf_alarm

`default_nettype wire
